/* include/sca_pkg.sv */
// constants, types and register map of the sensor channel acquisition block
package sca_pkg;
    localparam int NCH = 4;
    localparam int ADC_W = 16;
    // clock and timing
    localparam int CLK_HZ = 125_000_000;
    localparam int BASE_HZ = 100_000;
    localparam int TICK_CYC = CLK_HZ / BASE_HZ;
    localparam int BLINK_MS = 500;
    localparam int BLINK_CYC = (CLK_HZ / 1000) * BLINK_MS;
    localparam int SUPOFF_MS = 10;
    localparam int SUPOFF_CYC = (CLK_HZ / 1000) * SUPOFF_MS;
    localparam int DERATE_US = 1000;
    localparam int DERATE_CYC = (CLK_HZ / 1_000_000) * DERATE_US;
    localparam logic [31:0] AA_DELAY_TICKS = 32'h0000_0001;
    // rate codes: 0 = 100 kHz ... 16 = 0.5 Hz
    localparam logic [4:0] RATE_MAX_CODE = 5'h10;
    localparam logic [4:0] RP_MIN_CODE = 5'h03;
    localparam logic [4:0] RATE_RST = 5'h03;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_FAULT = 8'h0C;
    localparam logic [7:0] OFS_CIC = 8'h10;
    localparam logic [7:0] OFS_CHCFG = 8'h20;
    localparam logic [7:0] OFS_SUPPLY = 8'h30;
    localparam logic [7:0] OFS_DATA = 8'h40;
    localparam logic [7:0] OFS_TSTAMP = 8'h50;
    // field positions
    localparam int CTRL_RP_BIT = 0;
    localparam int CHCFG_BYP_BIT = 8;
    localparam int CHCFG_EFF_LSB = 16;
    localparam int SUP_EN_BIT = 0;
    localparam int SUP_SET_LSB = 8;
    localparam int STS_FUSE_LSB = 4;
    localparam int STS_OVL_LSB = 8;
    localparam int STS_RDY_LSB = 12;
    localparam logic [7:0] SUP_SET_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // lamp brightness
    typedef enum logic [1:0] {
        LVL_OFF = 2'b00,
        LVL_REDUCED = 2'b01,
        LVL_SEMI = 2'b10,
        LVL_FULL = 2'b11
    } lvl_e;
    typedef enum logic [2:0] {
        LAMP_NORMAL = 3'b000,
        LAMP_SUPPLY = 3'b001,
        LAMP_WARN = 3'b010,
        LAMP_INTERR = 3'b011,
        LAMP_SELFTEST = 3'b100
    } lamp_e;
    // asynchronous pin inputs
    typedef struct packed {
        logic [NCH-1:0][ADC_W-1:0] adc;
        logic [NCH-1:0] shrt;
        logic [NCH-1:0] fuse;
        logic [NCH-1:0] ovl;
        logic stfail;
        logic ierr;
        logic rpgo;
    } pin_s;
endpackage

/* rtl/sensor_channel_acquisition.sv */
// four-channel acquisition, supply control and status lamp with AXI4-Lite registers
`timescale 1ns/1ps
module sensor_channel_acquisition
    import sca_pkg::*;
#(
    parameter int BLINK_CYCLES = BLINK_CYC,
    parameter int SUPOFF_CYCLES = SUPOFF_CYC,
    parameter int DERATE_CYCLES = DERATE_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // axi4-lite write address and data
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // axi4-lite read
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // converters and sensor supplies
    output logic ADC_CONV,
    input wire logic [NCH-1:0][ADC_W-1:0] ADC_DATA,
    output logic [NCH-1:0] SUP_EN,
    output logic [NCH-1:0][7:0] SUP_SET,
    input wire logic [NCH-1:0] SUP_SHORT,
    input wire logic [NCH-1:0] SUP_FUSE,
    input wire logic [NCH-1:0] SUP_OVERLOAD,
    // module condition inputs
    input wire logic SELFTEST_FAIL,
    input wire logic INTERNAL_ERR,
    input wire logic RP_START,
    // lamp and interrupt
    output logic LED_RED,
    output logic LED_GREEN,
    output logic [1:0] LED_LEVEL,
    output logic IRQ
);
    typedef struct packed {
        pin_s s1;
        pin_s s2;
        logic rp_prev;
        logic rp_mode;
        logic [NCH-1:0][4:0] rate;
        logic [NCH-1:0] byp;
        logic [NCH-1:0] sup_en;
        logic [NCH-1:0][7:0] sup_set;
        logic [NCH-1:0][7:0] derate;
        logic [NCH-1:0] sup_out;
        logic [NCH-1:0][7:0] set_out;
        logic [15:0] sts;
        logic [15:0] msk;
        logic [10:0] tick;
        logic [31:0] tstamp;
        logic conv;
        logic [NCH-1:0][33:0] acc;
        logic [NCH-1:0][17:0] dec;
        logic [NCH-1:0][23:0] dat;
        logic [NCH-1:0][31:0] dts;
        logic [31:0] drt_cnt;
        logic [31:0] off_cnt;
        logic [31:0] blk_cnt;
        logic blk_ph;
        lamp_e lamp;
        logic led_r;
        logic led_g;
        logic [1:0] led_lvl;
        logic irq;
        logic awrdy;
        logic aw_ok;
        logic [7:0] awa;
        logic wrdy;
        logic w_ok;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] bresp;
        logic arrdy;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rresp;
    } st_s;

    localparam logic [10:0] TICK_LAST = 11'(TICK_CYC - 1);

    st_s r;
    st_s n;
    pin_s pins;

    // decimation ratio per rate code, lockstep to the 100 kHz base
    function automatic logic [17:0] rate_r(input logic [4:0] c);
        unique case (c)
            5'h00: rate_r = 18'h00001;
            5'h01: rate_r = 18'h00002;
            5'h02: rate_r = 18'h00005;
            5'h03: rate_r = 18'h0000A;
            5'h04: rate_r = 18'h00014;
            5'h05: rate_r = 18'h00032;
            5'h06: rate_r = 18'h00064;
            5'h07: rate_r = 18'h000C8;
            5'h08: rate_r = 18'h001F4;
            5'h09: rate_r = 18'h003E8;
            5'h0A: rate_r = 18'h007D0;
            5'h0B: rate_r = 18'h01388;
            5'h0C: rate_r = 18'h02710;
            5'h0D: rate_r = 18'h04E20;
            5'h0E: rate_r = 18'h0C350;
            5'h0F: rate_r = 18'h186A0;
            default: rate_r = 18'h30D40;
        endcase
    endfunction

    // gain correction: floor of log2 of the ratio, so output gain stays in [1,2)
    function automatic logic [4:0] rate_sh(input logic [4:0] c);
        unique case (c)
            5'h00: rate_sh = 5'h00;
            5'h01: rate_sh = 5'h01;
            5'h02: rate_sh = 5'h02;
            5'h03: rate_sh = 5'h03;
            5'h04: rate_sh = 5'h04;
            5'h05: rate_sh = 5'h05;
            5'h06: rate_sh = 5'h06;
            5'h07: rate_sh = 5'h07;
            5'h08: rate_sh = 5'h08;
            5'h09: rate_sh = 5'h09;
            5'h0A: rate_sh = 5'h0A;
            5'h0B: rate_sh = 5'h0C;
            5'h0C: rate_sh = 5'h0D;
            5'h0D: rate_sh = 5'h0E;
            5'h0E: rate_sh = 5'h0F;
            5'h0F: rate_sh = 5'h10;
            default: rate_sh = 5'h11;
        endcase
    endfunction

    // effective code after range limit and rapid-prototyping cap
    function automatic logic [4:0] eff_code(input logic [4:0] c, input logic rp);
        logic [4:0] e;
        e = (c > RATE_MAX_CODE) ? RATE_MAX_CODE : c;
        if (rp && (e < RP_MIN_CODE)) begin
            e = RP_MIN_CODE;
        end
        eff_code = e;
    endfunction

    // byte-lane merge for write strobes
    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] m;
        m = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                m[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        wmerge = m;
    endfunction

    assign pins = '{adc: ADC_DATA, shrt: SUP_SHORT, fuse: SUP_FUSE, ovl: SUP_OVERLOAD,
                    stfail: SELFTEST_FAIL, ierr: INTERNAL_ERR, rpgo: RP_START};

    // next-state logic for the whole block
    always_comb begin
        logic [15:0] set_v;
        logic [15:0] clr_v;
        logic [4:0] e;
        logic [17:0] rr;
        logic signed [33:0] smp;
        logic signed [33:0] sum;
        logic signed [33:0] shv;
        logic [31:0] wv;
        logic [31:0] rdv;
        logic [1:0] rsp;
        logic [1:0] ch;
        logic drt_pulse;
        n = r;
        set_v = '0;
        clr_v = '0;
        e = '0;
        rr = '0;
        smp = '0;
        sum = '0;
        shv = '0;
        wv = '0;
        rdv = '0;
        rsp = RESP_OKAY;
        ch = '0;
        drt_pulse = 1'b0;
        // two-stage synchronisers, second stage only is used
        n.s1 = pins;
        n.s2 = r.s1;
        n.rp_prev = r.s2.rpgo;
        n.conv = 1'b0;
        if (r.tick == TICK_LAST) begin
            n.tick = '0;
            n.conv = 1'b1;
            n.tstamp = r.tstamp + 32'h1;
        end else begin
            n.tick = r.tick + 11'h1;
        end
        // per-channel decimating comb, the data of the previous conversion is settled
        for (int c = 0; c < NCH; c++) begin
            e = eff_code(r.rate[c], r.rp_mode);
            rr = rate_r(e);
            if (r.conv) begin
                smp = {{18{r.s2.adc[c][ADC_W-1]}}, r.s2.adc[c]};
                sum = r.byp[c] ? smp : (r.acc[c] + smp);
                if (r.dec[c] >= (rr - 18'h1)) begin
                    shv = sum >>> rate_sh(e);
                    n.dat[c] = r.byp[c] ? smp[23:0] : shv[23:0];
                    n.dts[c] = r.tstamp - AA_DELAY_TICKS
                               - (r.byp[c] ? 32'h0 : {14'h0, (rr - 18'h1) >> 1});
                    set_v[STS_RDY_LSB + c] = 1'b1;
                    n.acc[c] = '0;
                    n.dec[c] = '0;
                end else begin
                    n.acc[c] = sum;
                    n.dec[c] = r.dec[c] + 18'h1;
                end
            end
        end
        // fault events; level inputs stay set while present
        set_v[3:0] = r.s2.shrt;
        set_v[7:4] = r.s2.fuse;
        set_v[11:8] = r.s2.ovl;
        // axi write: address and data taken independently
        if (r.awrdy && S_AXI_AWVALID) begin
            n.aw_ok = 1'b1;
            n.awa = S_AXI_AWADDR;
        end
        if (r.wrdy && S_AXI_WVALID) begin
            n.w_ok = 1'b1;
            n.wd = S_AXI_WDATA;
            n.ws = S_AXI_WSTRB;
        end
        if (r.bv && S_AXI_BREADY) begin
            n.bv = 1'b0;
        end
        if (r.aw_ok && r.w_ok && !r.bv) begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bv = 1'b1;
            ch = r.awa[3:2];
            rsp = RESP_OKAY;
            if (r.awa == OFS_CTRL) begin
                wv = wmerge({31'h0, r.rp_mode}, r.wd, r.ws);
                n.rp_mode = wv[CTRL_RP_BIT];
            end else if (r.awa == OFS_STATUS) begin
                wv = wmerge(32'h0, r.wd, r.ws);
                clr_v = wv[15:0];
            end else if (r.awa == OFS_MASK) begin
                wv = wmerge({16'h0, r.msk}, r.wd, r.ws);
                n.msk = wv[15:0];
            end else if (r.awa[7:4] == OFS_CHCFG[7:4]) begin
                wv = wmerge({23'h0, r.byp[ch], 3'h0, r.rate[ch]}, r.wd, r.ws);
                n.rate[ch] = wv[4:0];
                n.byp[ch] = wv[CHCFG_BYP_BIT];
            end else if (r.awa[7:4] == OFS_SUPPLY[7:4]) begin
                wv = wmerge({16'h0, r.sup_set[ch], 7'h0, r.sup_en[ch]}, r.wd, r.ws);
                n.sup_en[ch] = wv[SUP_EN_BIT];
                n.sup_set[ch] = wv[SUP_SET_LSB +: 8];
            end else if ((r.awa == OFS_CIC) || (r.awa == OFS_FAULT)
                         || (r.awa[7:4] == OFS_DATA[7:4])
                         || (r.awa[7:4] == OFS_TSTAMP[7:4])) begin
                rsp = RESP_SLVERR;
            end else begin
                rsp = RESP_DECERR;
            end
            n.bresp = rsp;
        end
        n.awrdy = !n.aw_ok;
        n.wrdy = !n.w_ok;
        // axi read: one outstanding, answer registered
        if (r.rv && S_AXI_RREADY) begin
            n.rv = 1'b0;
        end
        if (r.arrdy && S_AXI_ARVALID) begin
            ch = S_AXI_ARADDR[3:2];
            rsp = RESP_OKAY;
            if (S_AXI_ARADDR == OFS_CTRL) begin
                rdv = {31'h0, r.rp_mode};
            end else if (S_AXI_ARADDR == OFS_STATUS) begin
                rdv = {16'h0, r.sts};
            end else if (S_AXI_ARADDR == OFS_MASK) begin
                rdv = {16'h0, r.msk};
            end else if (S_AXI_ARADDR == OFS_FAULT) begin
                rdv = {20'h0, r.s2.ovl, r.s2.fuse, r.s2.shrt};
            end else if (S_AXI_ARADDR == OFS_CIC) begin
                rdv = {9'h0, rate_sh(eff_code(r.rate[0], r.rp_mode)),
                       rate_r(eff_code(r.rate[0], r.rp_mode))};
            end else if (S_AXI_ARADDR[7:4] == OFS_CHCFG[7:4]) begin
                rdv = {11'h0, eff_code(r.rate[ch], r.rp_mode), 7'h0, r.byp[ch],
                       3'h0, r.rate[ch]};
            end else if (S_AXI_ARADDR[7:4] == OFS_SUPPLY[7:4]) begin
                rdv = {16'h0, r.sup_set[ch], 7'h0, r.sup_en[ch]};
            end else if (S_AXI_ARADDR[7:4] == OFS_DATA[7:4]) begin
                rdv = {{8{r.dat[ch][23]}}, r.dat[ch]};
            end else if (S_AXI_ARADDR[7:4] == OFS_TSTAMP[7:4]) begin
                rdv = r.dts[ch];
            end else begin
                rsp = RESP_DECERR;
            end
            n.rv = 1'b1;
            n.rd = rdv;
            n.rresp = rsp;
        end
        n.arrdy = !n.rv;
        // short forces supply off, wins over a software enable
        for (int c = 0; c < NCH; c++) begin
            if (r.s2.shrt[c]) begin
                n.sup_en[c] = 1'b0;
            end
        end
        if (r.s2.rpgo && !r.rp_prev) begin
            n.off_cnt = 32'(SUPOFF_CYCLES);
        end else if (r.off_cnt != 32'h0) begin
            n.off_cnt = r.off_cnt - 32'h1;
        end
        if (|r.s2.ovl) begin
            if (r.drt_cnt == 32'(DERATE_CYCLES - 1)) begin
                n.drt_cnt = '0;
                drt_pulse = 1'b1;
            end else begin
                n.drt_cnt = r.drt_cnt + 32'h1;
            end
        end else begin
            n.drt_cnt = '0;
        end
        for (int c = 0; c < NCH; c++) begin
            if (!r.s2.ovl[c]) begin
                n.derate[c] = '0;
            end else if (drt_pulse && (r.derate[c] < r.sup_set[c])) begin
                n.derate[c] = r.derate[c] + 8'h1;
            end
            n.sup_out[c] = r.sup_en[c] && (r.off_cnt == 32'h0);
            n.set_out[c] = r.sup_set[c] - r.derate[c];
        end
        // status: a new event wins over a clear in the same cycle
        n.sts = (r.sts & ~clr_v) | set_v;
        n.irq = |(r.sts & r.msk);
        if (|r.s2.ovl) begin
            if (r.blk_cnt == 32'(BLINK_CYCLES - 1)) begin
                n.blk_cnt = '0;
                n.blk_ph = !r.blk_ph;
            end else begin
                n.blk_cnt = r.blk_cnt + 32'h1;
            end
        end else begin
            n.blk_cnt = '0;
            n.blk_ph = 1'b0;
        end
        // lamp priority: self-test, internal error, overload, supply on, normal
        if (r.s2.stfail) begin
            n.lamp = LAMP_SELFTEST;
        end else if (r.s2.ierr) begin
            n.lamp = LAMP_INTERR;
        end else if (|r.s2.ovl) begin
            n.lamp = LAMP_WARN;
        end else if ((|r.sup_en) && !(|r.s2.shrt) && !(|r.s2.fuse)) begin
            n.lamp = LAMP_SUPPLY;
        end else begin
            n.lamp = LAMP_NORMAL;
        end
        unique case (r.lamp)
            LAMP_SELFTEST: begin
                n.led_r = 1'b1;
                n.led_g = 1'b0;
                n.led_lvl = LVL_FULL;
            end
            LAMP_INTERR: begin
                n.led_r = 1'b1;
                n.led_g = 1'b0;
                n.led_lvl = LVL_SEMI;
            end
            LAMP_WARN: begin
                n.led_r = 1'b1;
                n.led_g = !r.blk_ph;
                n.led_lvl = LVL_REDUCED;
            end
            LAMP_SUPPLY: begin
                n.led_r = 1'b1;
                n.led_g = 1'b1;
                n.led_lvl = LVL_SEMI;
            end
            LAMP_NORMAL: begin
                n.led_r = 1'b0;
                n.led_g = 1'b1;
                n.led_lvl = LVL_SEMI;
            end
            default: begin
                n.led_r = 1'b1;
                n.led_g = 1'b0;
                n.led_lvl = LVL_SEMI;
            end
        endcase
    end

    // single state register; ready flags come up high after reset
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            r <= '0;
            r.awrdy <= 1'b1;
            r.wrdy <= 1'b1;
            r.arrdy <= 1'b1;
            r.rate <= {NCH{RATE_RST}};
            r.sup_set <= {NCH{SUP_SET_RST}};
            r.set_out <= {NCH{SUP_SET_RST}};
            r.lamp <= LAMP_NORMAL;
        end else begin
            r <= n;
        end
    end

    assign S_AXI_AWREADY = r.awrdy;
    assign S_AXI_WREADY = r.wrdy;
    assign S_AXI_BRESP = r.bresp;
    assign S_AXI_BVALID = r.bv;
    assign S_AXI_ARREADY = r.arrdy;
    assign S_AXI_RDATA = r.rd;
    assign S_AXI_RRESP = r.rresp;
    assign S_AXI_RVALID = r.rv;
    assign ADC_CONV = r.conv;
    assign SUP_EN = r.sup_out;
    assign SUP_SET = r.set_out;
    assign LED_RED = r.led_r;
    assign LED_GREEN = r.led_g;
    assign LED_LEVEL = r.led_lvl;
    assign IRQ = r.irq;
endmodule

/* verification/sca_checker.sv */
// port assertions of the acquisition block
`timescale 1ns/1ps
module sca_checker
    import sca_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // bus answers
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // pins
    input wire logic ADC_CONV,
    input wire logic [NCH-1:0] SUP_EN,
    input wire logic [NCH-1:0] SUP_SHORT,
    input wire logic [NCH-1:0] SUP_FUSE,
    input wire logic [NCH-1:0] SUP_OVERLOAD,
    input wire logic SELFTEST_FAIL,
    input wire logic INTERNAL_ERR,
    input wire logic RP_START,
    input wire logic LED_RED,
    input wire logic LED_GREEN,
    input wire logic [1:0] LED_LEVEL
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // no error and no supply fault; six cycles cover sync and lamp pipeline
    wire logic err = SELFTEST_FAIL | INTERNAL_ERR;
    wire logic calm = !(|{SUP_SHORT, SUP_FUSE, SUP_OVERLOAD}) && !err;
    conv_strobe_a: assert property (ADC_CONV |=> !ADC_CONV [*8])
        else $error("conversion strobe too long");
    selftest_lamp_a: assert property (SELFTEST_FAIL [*6] |->
        LED_RED && !LED_GREEN && LED_LEVEL == LVL_FULL) else $error("no red full");
    interr_lamp_a: assert property ((INTERNAL_ERR && !SELFTEST_FAIL) [*6] |->
        LED_RED && !LED_GREEN && LED_LEVEL == LVL_SEMI) else $error("no red semi");
    overload_lamp_a: assert property (((|SUP_OVERLOAD) && !err) [*6] |->
        LED_RED && LED_LEVEL == LVL_REDUCED) else $error("no reduced blink");
    supply_lamp_a: assert property (((|SUP_EN) && calm) [*6] |->
        LED_RED && LED_GREEN && LED_LEVEL == LVL_SEMI) else $error("no yellow semi");
    short_off_a: assert property ((SUP_SHORT & SUP_EN) != 0 |->
        ##[1:6] (SUP_SHORT & SUP_EN) == 0) else $error("shorted supply kept on");
    rp_gap_a: assert property ($rose(RP_START) && SUP_EN != 0 |->
        ##[1:8] SUP_EN == 0) else $error("supply not interrupted");
    write_once_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=>
        !S_AXI_BVALID) else $error("write answered twice");
    read_once_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=>
        !S_AXI_RVALID) else $error("read answered twice");
    // main scenarios reached
    cover property (LED_LEVEL == LVL_REDUCED);
    cover property ($fell(SUP_EN[0]));
    cover property (LED_LEVEL == LVL_FULL);
endmodule
bind sensor_channel_acquisition sca_checker chk (.CLK(CLK), .RSTN(RSTN),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .ADC_CONV(ADC_CONV), .SUP_EN(SUP_EN), .SUP_SHORT(SUP_SHORT),
    .SUP_FUSE(SUP_FUSE), .SUP_OVERLOAD(SUP_OVERLOAD),
    .SELFTEST_FAIL(SELFTEST_FAIL), .INTERNAL_ERR(INTERNAL_ERR),
    .RP_START(RP_START), .LED_RED(LED_RED), .LED_GREEN(LED_GREEN),
    .LED_LEVEL(LED_LEVEL));

/* verification/sca_front_model.sv */
// converter front end holding one result per channel between strobes
`timescale 1ns/1ps
module sca_front_model
    import sca_pkg::*;
#(
    parameter logic [NCH-1:0][ADC_W-1:0] VAL = '0
) (
    // clock and strobe
    input wire logic clk,
    input wire logic conv,
    // results
    output logic [NCH-1:0][ADC_W-1:0] adc
);
    // nothing converted yet: show the inverse, not a guess
    initial adc = ~VAL;
    always @(posedge clk) begin
        if (conv) begin
            adc <= VAL; // ready long before the next capture
        end
    end
endmodule

/* verification/sensor_channel_acquisition_bench.sv */
// self-checking bench of the acquisition block
`timescale 1ns/1ps
module sensor_channel_acquisition_bench;
    import sca_pkg::*;
    logic clk, rstn, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
    logic conv, stf, ierr, rps, led_r, led_g, irq;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd_;
    logic [1:0] bresp, rresp, led_l;
    logic [3:0] sup_en, sht, fus, ovl;
    logic [NCH-1:0][7:0] sup_set;
    logic [NCH-1:0][ADC_W-1:0] adc;
    int bad_count = 0, n_tests = 0, cyc = 0;
    sensor_channel_acquisition #(.BLINK_CYCLES(20), .SUPOFF_CYCLES(10),
        .DERATE_CYCLES(5)) uut (.CLK(clk), .RSTN(rstn), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rd_), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rr), .ADC_CONV(conv), .ADC_DATA(adc), .SUP_EN(sup_en),
        .SUP_SET(sup_set), .SUP_SHORT(sht), .SUP_FUSE(fus), .SUP_OVERLOAD(ovl),
        .SELFTEST_FAIL(stf), .INTERNAL_ERR(ierr), .RP_START(rps),
        .LED_RED(led_r), .LED_GREEN(led_g), .LED_LEVEL(led_l), .IRQ(irq));
    sca_front_model #(.VAL({16'h1111, 16'h2222, 16'h8123, 16'h7ABC})) fe (
        .clk(clk), .conv(conv), .adc(adc));
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // bus cycles: ready and answers sampled at the falling edge before use
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic [4:0] k;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        forever begin
            @(negedge clk);
            k = {awr, wr_, bv, bresp};
            @(posedge clk);
            if (k[4]) awv <= 1'b0;
            if (k[3]) wv <= 1'b0;
            if (k[2]) break;
        end
        br <= 1'b0;
        cmp(k[1:0], e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic [35:0] k;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        forever begin
            @(negedge clk);
            k = {arr, rv, rresp, rd_};
            @(posedge clk);
            if (k[35]) arv <= 1'b0;
            if (k[34]) break;
        end
        rr <= 1'b0;
        d = k[31:0];
        r = k[33:32];
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        cmp(d & m, e);
        cmp(r, RESP_OKAY);
    endtask
    // live view of one output group, read when the compare runs
    function automatic logic [31:0] obs(input int s);
        case (s)
            0: obs = 32'(irq);
            1: obs = 32'({sup_en, sup_set[0]});
            2: obs = 32'(sup_en[0] && sup_set[0] < 8'hC8 && sup_set[0] > 8'hB8);
            3: obs = 32'(sup_set[0]);
            4: obs = 32'(sup_en);
            default: obs = 32'({led_r, led_g, led_l});
        endcase
    endfunction
    // outputs settled at the falling edge; hand back on a rising edge
    task automatic pin(input int s, input logic [31:0] e, input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
        cmp(obs(s), e);
        @(posedge clk);
    endtask
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        rc(OFS_CTRL, 0, 32'h1);
        rc(OFS_MASK, 0, 32'hFFFF);
        rc(OFS_CHCFG, RATE_RST, 32'h11F);
        rd(8'hFC, d, r);
        cmp(r, RESP_DECERR);
        wr(OFS_CIC, 32'h1, RESP_SLVERR);
    endtask
    task automatic t_rate;
        for (int c = 0; c < 3; c++) begin
            wr(OFS_CHCFG, c, RESP_OKAY);
            rc(OFS_CHCFG, c << CHCFG_EFF_LSB, 32'h1F0000);
            wr(OFS_CTRL, 1, RESP_OKAY);
            rc(OFS_CHCFG, {11'h0, RP_MIN_CODE, 16'h0}, 32'h1F0000);
            wr(OFS_CTRL, 0, RESP_OKAY);
        end
        wr(OFS_CHCFG, 32'h11, RESP_OKAY);
        rc(OFS_CHCFG, {11'h0, RATE_MAX_CODE, 16'h0}, 32'h1F0000);
    endtask
    task automatic t_data;
        logic [31:0] d;
        logic [1:0] r;
        wr(OFS_CHCFG, 32'h1, RESP_OKAY);
        wr(OFS_CHCFG + 8'h4, 32'h100, RESP_OKAY);
        // two rounds: the first may still hold samples from before the first conversion
        repeat (2) begin
            wr(OFS_STATUS, 32'h3000, RESP_OKAY);
            for (int i = 0; i < 3000; i++) begin
                rd(OFS_STATUS, d, r);
                if ((d & 32'h3000) == 32'h3000) break;
            end
        end
        rc(OFS_DATA, 32'h7ABC, '1);
        rc(OFS_DATA + 8'h4, 32'hFFFF8123, '1);
    endtask
    task automatic t_irq;
        wr(OFS_MASK, 32'h40, RESP_OKAY);
        fus <= 4'h4;
        // two synchroniser stages plus status and interrupt registers
        repeat (4) @(posedge clk);
        rc(OFS_FAULT, 32'h40, 32'hFFF);
        pin(0, 1, 0);
        fus <= 4'h0;
        rc(OFS_STATUS, 32'h40, 32'hFFF);
        wr(OFS_STATUS, 32'h40, RESP_OKAY);
        pin(0, 0, 2);
        wr(OFS_MASK, 0, RESP_OKAY);
        fus <= 4'h4;
        pin(0, 0, 6);
        fus <= 4'h0;
    endtask
    task automatic t_supply;
        wr(OFS_SUPPLY, 32'hC801, RESP_OKAY);
        pin(1, 12'h1C8, 2);
        ovl <= 4'h1;
        pin(2, 1, 40);
        ovl <= 4'h0;
        pin(3, 8'hC8, 12);
        sht <= 4'h1;
        pin(4, 0, 8);
        rc(OFS_FAULT, 32'h1, 32'hFFF);
        sht <= 4'h0;
        rc(OFS_SUPPLY, 32'hC800, 32'hFF01);
        wr(OFS_SUPPLY, 32'hC801, RESP_OKAY);
        rps <= 1'b1;
        pin(4, 0, 5);
        rps <= 1'b0;
        pin(4, 1, 20);
    endtask
    task automatic t_lamp;
        stf <= 1'b1;
        pin(5, {2'b10, LVL_FULL}, 8);
        stf <= 1'b0;
        ierr <= 1'b1;
        pin(5, {2'b10, LVL_SEMI}, 8);
        ierr <= 1'b0;
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang guard well above the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            bad_count++;
            conclude;
        end
    end
    initial begin
        {rstn, awv, wv, br, arv, rr, stf, ierr, rps} = '0;
        {awa, ara, wd, sht, fus, ovl} = '0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_rate;
        t_data;
        t_irq;
        t_supply;
        t_lamp;
        conclude;
    end
endmodule
